// ### core/smi2c_defs.svh
// timing and field constants for the serial memory two-wire slave
`ifndef SMI2C_DEFS_SVH
`define SMI2C_DEFS_SVH
`define SMI2C_MEM_PREFIX 4'b1010
`define SMI2C_HS_CODE 5'b0000_1
`define SMI2C_ADDR_W 16
`define SMI2C_ADDR_RST 16'h0000
`define SMI2C_ADDR_LAST 16'hFFFF
`define SMI2C_CLK_HZ 50000000
`define SMI2C_FSCL_MAX_HZ 3400000
`define SMI2C_MIN_SAMPLES_PER_HALF ((`SMI2C_CLK_HZ / (2 * `SMI2C_FSCL_MAX_HZ)))
`endif

// ### core/smi2c_pkg.sv
// types for the serial memory two-wire slave
package smi2c_pkg;
    typedef enum logic [2:0]
    {
        SMI2C_IDLE = 3'b000,
        SMI2C_SEL = 3'b001,
        SMI2C_ADDR_HI = 3'b010,
        SMI2C_ADDR_LO = 3'b011,
        SMI2C_WDATA = 3'b100,
        SMI2C_RDATA = 3'b101,
        SMI2C_IGNORE = 3'b110
    } smi2c_state_t;
endpackage : smi2c_pkg

// ### core/smi2c_slave.sv
// two-wire memory slave front end with synchronisers and byte engine
// Summary of operation
// - only seven-bit slave addresses are recognised after a start
// - eighth select bit: one means read, zero means write
// - matching select byte is acknowledged and transaction continues
// - non-matching select: ignore data line until stop or repeated start
// - receiver drives data low in the ninth clock to acknowledge
// - write address increments at end of ninth clock, read address at its start
// - address wraps from top to zero, bursts keep going
// - stop or repeated start ends a write burst
// - reads start at current address, next after last access
// - address-only write then restart sets read address, stores nothing
// - master nack on read makes device release data line
// - data changes only while clock low except start and stop
// - start is data falling while clock high
// - stop is data rising while clock high, ends transaction
// - bus busy from start until stop
// - repeated start abandons transaction, bus stays busy, expects select
// - bytes are eight bits, msb first, then acknowledge slot
// - transmitter releases data line after a byte for acknowledge
// - missing acknowledge aborts the current operation
// - protected write bytes are not acknowledged
// - works up to high-speed bus clock rate
// - memory address is sixteen bits, high byte first
// - memory selected by fixed prefix and matching strap bits
// - high-speed master code is not acknowledged, mode ends at stop
`timescale 1ns/10ps
`include "smi2c_defs.svh"
module smi2c_slave
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic [2:0] strap_in,
    input wire logic write_protect_in,
    input wire logic [7:0] mem_rdata_in,
    output logic sda_out,
    output logic sda_oe_out,
    output logic [15:0] mem_addr_out,
    output logic [7:0] mem_wdata_out,
    output logic mem_we_out,
    output logic bus_busy_out,
    output logic hs_mode_out
);
    // ==========================================================
    // synchronisers and edge detection
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_d;
    logic sda_d;
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
        end
    end
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl_rise = scl_sync[1] & ~scl_d;
    assign scl_fall = ~scl_sync[1] & scl_d;
    assign start_det = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
    assign stop_det = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

    // ==========================================================
    // decode helpers
    function automatic logic sel_match(input logic [7:0] b, input logic [2:0] s);
        sel_match = (b[7:4] == `SMI2C_MEM_PREFIX) && (b[3:1] == s);
    endfunction : sel_match
    function automatic logic is_hs_code(input logic [7:0] b);
        is_hs_code = (b[7:3] == `SMI2C_HS_CODE);
    endfunction : is_hs_code

    // ==========================================================
    // bit engine state
    smi2c_pkg::smi2c_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] txreg;
    logic ack_slot;
    logic ack_drive;
    logic master_nack;
    logic [7:0] addr_hi;
    logic [2:0] strap;
    // strap pins are resampled every clock after reset release through the synchroniser path
    logic [1:0] strap_s0;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            strap_s0 <= 2'h0;
            strap_s1 <= 2'h0;
            strap_s2 <= 2'h0;
            strap <= 3'h0;
        end
        else
        begin
            strap_s0 <= {strap_s0[0], strap_in[0]};
            strap_s1 <= {strap_s1[0], strap_in[1]};
            strap_s2 <= {strap_s2[0], strap_in[2]};
            strap <= {strap_s2[1], strap_s1[1], strap_s0[1]};
        end
    end
    logic [1:0] wp_sync;
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            wp_sync <= 2'h0;
        else
            wp_sync <= {wp_sync[0], write_protect_in};
    end

    logic [7:0] rx_byte;
    assign rx_byte = {shreg[6:0], sda_sync[1]};

    // ==========================================================
    // bus busy and high-speed mode
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            bus_busy_out <= 1'b0;
        else if (stop_det)
            bus_busy_out <= 1'b0;
        else if (start_det)
            bus_busy_out <= 1'b1;
    end
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            hs_mode_out <= 1'b0;
        else if (stop_det)
            hs_mode_out <= 1'b0;
        else if (scl_rise && state == smi2c_pkg::SMI2C_SEL && bitcnt == 4'h7
                 && is_hs_code(rx_byte))
            hs_mode_out <= 1'b1;
    end

    // ==========================================================
    // byte engine: bits sampled on rising scl, moved on falling scl
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state <= smi2c_pkg::SMI2C_IDLE;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            txreg <= 8'h00;
            ack_slot <= 1'b0;
            ack_drive <= 1'b0;
            master_nack <= 1'b0;
            addr_hi <= 8'h00;
            mem_addr_out <= `SMI2C_ADDR_RST;
            mem_wdata_out <= 8'h00;
            mem_we_out <= 1'b0;
            sda_out <= 1'b0;
            sda_oe_out <= 1'b0;
        end
        else
        begin
            mem_we_out <= 1'b0;
            sda_out <= 1'b0;
            if (stop_det)
            begin
                state <= smi2c_pkg::SMI2C_IDLE;
                sda_oe_out <= 1'b0;
                ack_slot <= 1'b0;
            end
            else if (start_det)
            begin
                state <= smi2c_pkg::SMI2C_SEL;
                bitcnt <= 4'h0;
                sda_oe_out <= 1'b0;
                ack_slot <= 1'b0;
            end
            else if (scl_rise && state != smi2c_pkg::SMI2C_IDLE
                     && state != smi2c_pkg::SMI2C_IGNORE)
            begin
                if (ack_slot)
                    master_nack <= sda_sync[1];
                else
                begin
                    shreg <= rx_byte;
                    bitcnt <= bitcnt + 4'h1;
                end
            end
            else if (scl_fall && state != smi2c_pkg::SMI2C_IDLE
                     && state != smi2c_pkg::SMI2C_IGNORE)
            begin
                if (!ack_slot && bitcnt == 4'h8)
                begin
                    // ninth clock begins: decide acknowledge, step read address
                    ack_slot <= 1'b1;
                    bitcnt <= 4'h0;
                    ack_drive <= 1'b0;
                    sda_oe_out <= 1'b0;
                    case (state)
                        smi2c_pkg::SMI2C_SEL:
                        begin
                            if (sel_match(shreg, strap))
                            begin
                                ack_drive <= 1'b1;
                                sda_oe_out <= 1'b1;
                            end
                        end
                        smi2c_pkg::SMI2C_ADDR_HI, smi2c_pkg::SMI2C_ADDR_LO:
                        begin
                            ack_drive <= 1'b1;
                            sda_oe_out <= 1'b1;
                        end
                        smi2c_pkg::SMI2C_WDATA:
                        begin
                            if (!wp_sync[1])
                            begin
                                ack_drive <= 1'b1;
                                sda_oe_out <= 1'b1;
                                mem_wdata_out <= shreg;
                                mem_we_out <= 1'b1;
                            end
                        end
                        smi2c_pkg::SMI2C_RDATA:
                        begin
                            // next read byte address stepped and fetched
                            mem_addr_out <= mem_addr_out + 16'h0001;
                        end
                        default:
                        begin
                            ack_drive <= 1'b0;
                        end
                    endcase
                end
                else if (ack_slot)
                begin
                    // end of ninth clock: move to next phase
                    ack_slot <= 1'b0;
                    sda_oe_out <= 1'b0;
                    case (state)
                        smi2c_pkg::SMI2C_SEL:
                        begin
                            if (!ack_drive)
                                state <= smi2c_pkg::SMI2C_IGNORE;
                            else if (shreg[0])
                            begin
                                state <= smi2c_pkg::SMI2C_RDATA;
                                txreg <= {mem_rdata_in[6:0], 1'b0};
                                sda_oe_out <= ~mem_rdata_in[7];
                            end
                            else
                                state <= smi2c_pkg::SMI2C_ADDR_HI;
                        end
                        smi2c_pkg::SMI2C_ADDR_HI:
                        begin
                            addr_hi <= shreg;
                            state <= smi2c_pkg::SMI2C_ADDR_LO;
                        end
                        smi2c_pkg::SMI2C_ADDR_LO:
                        begin
                            mem_addr_out <= {addr_hi, shreg};
                            state <= smi2c_pkg::SMI2C_WDATA;
                        end
                        smi2c_pkg::SMI2C_WDATA:
                        begin
                            if (ack_drive)
                                mem_addr_out <= mem_addr_out + 16'h0001;
                            else
                                state <= smi2c_pkg::SMI2C_IGNORE;
                        end
                        smi2c_pkg::SMI2C_RDATA:
                        begin
                            if (master_nack)
                                state <= smi2c_pkg::SMI2C_IGNORE;
                            else
                            begin
                                txreg <= {mem_rdata_in[6:0], 1'b0};
                                sda_oe_out <= ~mem_rdata_in[7];
                            end
                        end
                        default:
                        begin
                            state <= smi2c_pkg::SMI2C_IGNORE;
                        end
                    endcase
                end
                else if (state == smi2c_pkg::SMI2C_RDATA)
                begin
                    // shift next read bit out while clock low
                    if (bitcnt == 4'h8)
                        sda_oe_out <= 1'b0;
                    else
                    begin
                        sda_oe_out <= ~txreg[7];
                        txreg <= {txreg[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // ==========================================================
    // checks
    property p_start_busy;
        @(posedge clk_in) disable iff (rst_in)
        start_det && !stop_det |=> bus_busy_out;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("busy not set");
    property p_stop_idle;
        @(posedge clk_in) disable iff (rst_in)
        stop_det |=> state == smi2c_pkg::SMI2C_IDLE && !sda_oe_out && !hs_mode_out;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");
    property p_open_drain;
        @(posedge clk_in) disable iff (rst_in)
        !sda_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("sda driven high");
    property p_sda_stable_high;
        @(posedge clk_in) disable iff (rst_in)
        scl_sync[1] && scl_d && !start_det && !stop_det |=> $stable(sda_oe_out);
    endproperty
    a_sda_stable_high: assert property (p_sda_stable_high) else $error("sda moved");
    property p_ignore_quiet;
        @(posedge clk_in) disable iff (rst_in)
        state == smi2c_pkg::SMI2C_IGNORE && !start_det |=> !sda_oe_out && !mem_we_out;
    endproperty
    a_ignore_quiet: assert property (p_ignore_quiet) else $error("ignored bus driven");
    property p_restart_sel;
        @(posedge clk_in) disable iff (rst_in)
        start_det && !stop_det |=> state == smi2c_pkg::SMI2C_SEL && bitcnt == 4'h0;
    endproperty
    a_restart_sel: assert property (p_restart_sel) else $error("no fresh select");
    property p_wp_no_write;
        @(posedge clk_in) disable iff (rst_in)
        wp_sync[1] && $past(wp_sync[1]) |-> !mem_we_out;
    endproperty
    a_wp_no_write: assert property (p_wp_no_write) else $error("protected write");
    property p_write_step;
        @(posedge clk_in) disable iff (rst_in)
        mem_we_out |-> ##[1:1000] ((mem_addr_out == $past(mem_addr_out) + 16'h0001)
            || state != smi2c_pkg::SMI2C_WDATA);
    endproperty
    a_write_step: assert property (p_write_step) else $error("address not stepped");
endmodule : smi2c_slave

// ### test/serial_memory_i2c_slave_tb.sv
// self-checking bench of the two-wire memory slave
`timescale 1ns/10ps
`include "smi2c_defs.svh"
module serial_memory_i2c_slave_tb;
    localparam logic [7:0] SEL_W = {`SMI2C_MEM_PREFIX, 3'b101, 1'b0};
    localparam logic [7:0] SEL_R = {`SMI2C_MEM_PREFIX, 3'b101, 1'b1};
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [2:0] strap = 3'b101;
    logic wp = 1'b0;
    logic sda_out, sda_oe, mem_we, busy, hs, scl_m, pull_m;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata, rdata;
    logic [7:0] mem [0:65535];
    int num_errors = 0;
    int check_count = 0;
    int wr_count = 0;
    wire logic scl_w = scl_m;
    wire logic sda_w = ~(sda_oe | pull_m);
    assign rdata = mem[mem_addr];
    always #10 clk_in = ~clk_in;
    // ==========================================
    // memory model behind the slave
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : pat
    initial
    begin
        for (int a = 0; a < 65536; a++)
            mem[a] = pat(16'(a));
        forever
        begin
            @(posedge clk_in);
            if (mem_we === 1'b1)
            begin
                mem[mem_addr] <= mem_wdata;
                wr_count <= wr_count + 1;
            end
        end
    end
    smi2c_slave DUT (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_w), .sda_in(sda_w),
        .strap_in(strap), .write_protect_in(wp), .mem_rdata_in(rdata), .sda_out(sda_out),
        .sda_oe_out(sda_oe), .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata),
        .mem_we_out(mem_we), .bus_busy_out(busy), .hs_mode_out(hs));
    smi2c_master_model M (.sda_in(sda_w), .scl_out(scl_m), .sda_pull_out(pull_m));
    // ==========================================
    // shared helpers
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wb(input logic [7:0] d, input logic exp_ack, input string what);
        logic a;
        M.write_byte(d, a);
        check(what, {15'h0000, exp_ack}, {15'h0000, a});
    endtask : wb
    task automatic rb(input logic ack, input logic [7:0] exp, input string what);
        logic [7:0] d;
        M.read_byte(ack, d);
        check(what, {8'h00, exp}, {8'h00, d});
    endtask : rb
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // ==========================================
    // scenarios
    task automatic t_write_wrap();
        int w0 = wr_count;
        M.start_cond();
        wb(SEL_W, 1'b1, "select ack");
        check("busy", 16'h0001, {15'h0000, busy});
        wb(8'hff, 1'b1, "addr hi ack");
        wb(8'hfe, 1'b1, "addr lo ack");
        wb(8'ha1, 1'b1, "data ack");
        wb(8'hb2, 1'b1, "data ack");
        wb(8'hc3, 1'b1, "wrap data ack");
        M.stop_cond();
        check("busy after stop", 16'h0000, {15'h0000, busy});
        check("mem fffe", 16'h00a1, {8'h00, mem[16'hfffe]});
        check("mem ffff", 16'h00b2, {8'h00, mem[16'hffff]});
        check("mem 0000", 16'h00c3, {8'h00, mem[16'h0000]});
        check("write count", 16'h0003, 16'(wr_count - w0));
        check("addr after wrap", 16'h0001, mem_addr);
    endtask : t_write_wrap
    task automatic t_cur_read();
        M.start_cond();
        wb(SEL_R, 1'b1, "read select ack");
        rb(1'b1, pat(16'h0001), "current read");
        rb(1'b0, pat(16'h0002), "next read");
        #100;
        check("release after nack", 16'h0000, {15'h0000, sda_oe});
        M.stop_cond();
    endtask : t_cur_read
    task automatic t_random_read();
        int w0 = wr_count;
        M.start_cond();
        wb(SEL_W, 1'b1, "select ack");
        wb(8'h12, 1'b1, "addr hi ack");
        wb(8'h34, 1'b1, "addr lo ack");
        M.start_cond();
        check("busy at restart", 16'h0001, {15'h0000, busy});
        wb(SEL_R, 1'b1, "reselect ack");
        rb(1'b0, pat(16'h1234), "random read");
        M.stop_cond();
        check("no write", 16'h0000, 16'(wr_count - w0));
    endtask : t_random_read
    task automatic t_no_match(input logic [7:0] sel);
        int w0 = wr_count;
        M.start_cond();
        wb(sel, 1'b0, "foreign select nack");
        wb(8'h00, 1'b0, "ignored byte");
        wb(8'h55, 1'b0, "ignored byte");
        M.stop_cond();
        check("no write", 16'h0000, 16'(wr_count - w0));
    endtask : t_no_match
    task automatic t_protect();
        int w0 = wr_count;
        @(posedge clk_in);
        #1 wp = 1'b1;
        M.start_cond();
        wb(SEL_W, 1'b1, "select ack");
        wb(8'h00, 1'b1, "addr hi ack");
        wb(8'h10, 1'b1, "addr lo ack");
        wb(8'h77, 1'b0, "protected nack");
        M.stop_cond();
        check("protected mem", {8'h00, pat(16'h0010)}, {8'h00, mem[16'h0010]});
        check("no write", 16'h0000, 16'(wr_count - w0));
        @(posedge clk_in);
        #1 wp = 1'b0;
    endtask : t_protect
    task automatic t_hs();
        M.start_cond();
        wb(8'h0d, 1'b0, "hs code nack");
        M.start_cond();
        check("hs mode", 16'h0001, {15'h0000, hs});
        wb(SEL_R, 1'b1, "hs select ack");
        rb(1'b0, pat(16'h0010), "hs read");
        M.stop_cond();
        check("hs ends at stop", 16'h0000, {15'h0000, hs});
    endtask : t_hs
    // ==========================================
    // main sequence and watchdog
    initial
    begin
        repeat (8) @(posedge clk_in);
        #1 rst_in = 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        check("reset addr", 16'h0000, mem_addr);
        check("reset oe", 16'h0000, {15'h0000, sda_oe});
        check("sda out", 16'h0000, {15'h0000, sda_out});
        t_write_wrap();
        t_cur_read();
        t_random_read();
        t_no_match({`SMI2C_MEM_PREFIX, 3'b010, 1'b0});
        t_no_match(8'h3a);
        t_protect();
        t_hs();
        end_sim();
    end
    initial
    begin
        #500000;
        num_errors++;
        end_sim();
    end
endmodule : serial_memory_i2c_slave_tb

// ### test/smi2c_master_model.sv
// two-wire bus master model that drives the clock line
`timescale 1ns/10ps
module smi2c_master_model
(
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_pull_out
);
    // quarter of the 160 ns bus clock period
    localparam int QTR = 40;
    initial
    begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
    end
    // ==========================================
    // bus conditions
    // start or repeated start, clock left low
    task automatic start_cond();
        sda_pull_out = 1'b0;
        // full low half so a slave ack is gone before clock rises
        #(2 * QTR) scl_out = 1'b1;
        #(2 * QTR) sda_pull_out = 1'b1;
        #(2 * QTR) scl_out = 1'b0;
    endtask : start_cond
    // stop, then both lines left released
    task automatic stop_cond();
        #QTR sda_pull_out = 1'b1;
        #QTR scl_out = 1'b1;
        #(2 * QTR) sda_pull_out = 1'b0;
        #(4 * QTR);
    endtask : stop_cond
    // ==========================================
    // bit and byte transfer
    // data set mid-low, sampled at end of high
    task automatic clock_bit(input logic b, output logic seen);
        #QTR sda_pull_out = ~b;
        #QTR scl_out = 1'b1;
        #(2 * QTR) seen = sda_in;
        scl_out = 1'b0;
    endtask : clock_bit
    // msb first, ninth clock released for the slave ack
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clock_bit(d[i], s);
        clock_bit(1'b1, s);
        ack = ~s;
    endtask : write_byte
    // master ack or nack in the ninth clock
    task automatic read_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            clock_bit(1'b1, d[i]);
        clock_bit(~ack, s);
    endtask : read_byte
endmodule : smi2c_master_model
